// [cclut_defines.vh]
// Register offsets, field positions, reset values and timing for the logic block.
`ifndef CCLUT_DEFINES_VH
`define CCLUT_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCLUT_ADDR_GLOBAL_CONTROL 4'h0
`define CCLUT_ADDR_PAIR_SEQ_CONTROL 4'h1
`define CCLUT_ADDR_STATUS 4'h2
`define CCLUT_ADDR_T0_CONTROL_A 4'h5
`define CCLUT_ADDR_T0_CONTROL_B 4'h6
`define CCLUT_ADDR_T0_CONTROL_C 4'h7
`define CCLUT_ADDR_T0_TRUTH 4'h8
`define CCLUT_ADDR_T1_CONTROL_A 4'h9
`define CCLUT_ADDR_T1_CONTROL_B 4'hA
`define CCLUT_ADDR_T1_CONTROL_C 4'hB
`define CCLUT_ADDR_T1_TRUTH 4'hC
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCLUT_GC_ENABLE 0
`define CCLUT_CA_ENABLE 0
`define CCLUT_CA_OUTEN 3
`define CCLUT_CA_FILT_LO 4
`define CCLUT_CA_FILT_HI 5
`define CCLUT_CA_CLKSEL 6
`define CCLUT_CA_EDGE 7
`define CCLUT_CB_IN0_LO 0
`define CCLUT_CB_IN0_HI 3
`define CCLUT_CB_IN1_LO 4
`define CCLUT_CB_IN1_HI 7
`define CCLUT_CC_IN2_LO 0
`define CCLUT_CC_IN2_HI 3
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCLUT_RST_BYTE 8'h00
`define CCLUT_RST_SEQ 4'h0
// ----------------------------------------------------------------
// Input sources
// ----------------------------------------------------------------
`define CCLUT_SRC_MASK 4'h0
`define CCLUT_SRC_FEEDBACK 4'h1
`define CCLUT_SRC_LINK 4'h2
`define CCLUT_SRC_EVENT_LINE_ZERO 4'h3
`define CCLUT_SRC_EVENT_LINE_ONE 4'h4
`define CCLUT_SRC_PIN 4'h5
`define CCLUT_SRC_COMPARATOR 4'h6
`define CCLUT_SRC_TIMER_A 4'h7
`define CCLUT_SRC_TIMER_B 4'h8
// ----------------------------------------------------------------
// Sequential functions and filter modes
// ----------------------------------------------------------------
`define CCLUT_SEQ_OFF 4'h0
`define CCLUT_SEQ_DFF 4'h1
`define CCLUT_SEQ_JK 4'h2
`define CCLUT_SEQ_DLATCH 4'h3
`define CCLUT_SEQ_RS 4'h4
`define CCLUT_FILT_OFF 2'h0
`define CCLUT_FILT_SYNC 2'h1
`define CCLUT_FILT_FILTER 2'h2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCLUT_CLOCK_MHZ 100
`endif

// [cclut_logic.v]
// Configurable look-up table pair with shared sequential element.
`timescale 1ns/1ns
//
// Notes on behaviour
// R01: Output is truth bit indexed by inputs, input 2 most significant.
// R02: A masked input enters the index as low.
// R03: Global enable bit turns the whole block on or off.
// R04: Each table has its own enable bit in control A.
// R05: Sequential function select writable only while table 0 disabled.
// R06: Table control fields besides enable writable only while disabled; control A also takes any write with enable set.
// R07: Protected bits update with an enabling write, never a disabling one.
// R08: Table clocked logic uses clock or input 2 when clock-select set.
// R09: Sequential element uses the clock chosen for table 0.
// R10: Software clears global enable before changing clock select.
// R11: Feedback source gives both tables the sequential output.
// R12: Link source gives table n the direct output of table n+1.
// R13: Two event lines are selectable; software routes events first.
// R14: Input 0 and 1 selects in control B, input 2 in control C.
// R15: Inputs come from pins, events, comparator, timers, sub-blocks.
// R16: Sequential element is D flip-flop, JK, D latch or RS latch.
// R17: Outputs go to pins and events via optional sync or filter.
// R18: Block keeps running while the processor is halted.
// R19: Block raises no interrupts.
// R20: With clock-select set, input 2 enters the index as low.
// R21: Filter delays output four cycles and clears on disable.
// R22: Disabled tables drive low and hold clocked state cleared.

`include "cclut_defines.vh"

module cclut_logic #(
  parameter NUM_TABLES = 2
) (
  // Clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [7:0] reg_rdata,
  // Table sources, pins 3n to 3n+2 and timer bit n belong to table n
  input wire [3*NUM_TABLES-1:0] table_input_pins,
  input wire event_line_zero,
  input wire event_line_one,
  input wire comparator_out,
  input wire [1:0] timer_waveform,
  // Debug halt from the processor, deliberately ignored
  input wire debug_halt,
  // Results
  output reg [NUM_TABLES-1:0] table_output_pin,
  output reg [NUM_TABLES-1:0] table_output_pin_oe,
  output reg [NUM_TABLES-1:0] table_output_event,
  output reg pair_sequential_output
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg global_enable_q;
  reg [3:0] sequential_function_select_q;
  reg [7:0] table_control_a_q [0:1];
  reg [7:0] table_control_b_q [0:1];
  reg [7:0] table_control_c_q [0:1];
  reg [7:0] table_truth_bits_q [0:1];

  wire [1:0] tbl_en;
  wire [1:0] run;
  assign tbl_en[0] = table_control_a_q[0][`CCLUT_CA_ENABLE];
  assign tbl_en[1] = table_control_a_q[1][`CCLUT_CA_ENABLE];
  assign run = tbl_en & {2{global_enable_q}}; // R22

  // A protected write lands while the table is off, or with an enabling
  // write; the disabling write only clears enable.
  wire [1:0] prot_ok;
  assign prot_ok[0] = ~tbl_en[0] | reg_wdata[`CCLUT_CA_ENABLE]; // R06 R07
  assign prot_ok[1] = ~tbl_en[1] | reg_wdata[`CCLUT_CA_ENABLE]; // R06 R07
  wire [1:0] prot_bc;
  assign prot_bc = ~tbl_en; // R06

  integer k;
  always @(posedge clk) begin
    if (sys_rst) begin
      global_enable_q <= 1'b0;
      sequential_function_select_q <= `CCLUT_RST_SEQ;
      for (k = 0; k < 2; k = k + 1) begin
        table_control_a_q[k] <= `CCLUT_RST_BYTE;
        table_control_b_q[k] <= `CCLUT_RST_BYTE;
        table_control_c_q[k] <= `CCLUT_RST_BYTE;
        table_truth_bits_q[k] <= `CCLUT_RST_BYTE;
      end
    end else if (clk_en && reg_we) begin
      case (reg_addr)
        `CCLUT_ADDR_GLOBAL_CONTROL: begin
          global_enable_q <= reg_wdata[`CCLUT_GC_ENABLE]; // R03
        end
        `CCLUT_ADDR_PAIR_SEQ_CONTROL: begin
          if (!tbl_en[0]) begin
            sequential_function_select_q <= reg_wdata[3:0]; // R05
          end
        end
        `CCLUT_ADDR_T0_CONTROL_A: begin
          if (prot_ok[0]) table_control_a_q[0] <= reg_wdata; // R04 R07
          else table_control_a_q[0][`CCLUT_CA_ENABLE] <= 1'b0; // R04
        end
        `CCLUT_ADDR_T1_CONTROL_A: begin
          if (prot_ok[1]) table_control_a_q[1] <= reg_wdata; // R04 R07
          else table_control_a_q[1][`CCLUT_CA_ENABLE] <= 1'b0; // R04
        end
        `CCLUT_ADDR_T0_CONTROL_B: begin
          if (prot_bc[0]) table_control_b_q[0] <= reg_wdata; // R14
        end
        `CCLUT_ADDR_T0_CONTROL_C: begin
          if (prot_bc[0]) table_control_c_q[0] <= reg_wdata; // R14
        end
        `CCLUT_ADDR_T0_TRUTH: begin
          if (prot_bc[0]) table_truth_bits_q[0] <= reg_wdata; // R06
        end
        `CCLUT_ADDR_T1_CONTROL_B: begin
          if (prot_bc[1]) table_control_b_q[1] <= reg_wdata; // R14
        end
        `CCLUT_ADDR_T1_CONTROL_C: begin
          if (prot_bc[1]) table_control_c_q[1] <= reg_wdata; // R14
        end
        `CCLUT_ADDR_T1_TRUTH: begin
          if (prot_bc[1]) table_truth_bits_q[1] <= reg_wdata; // R06
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_re) begin
        case (reg_addr)
          `CCLUT_ADDR_GLOBAL_CONTROL: reg_rdata <= {7'h00, global_enable_q};
          `CCLUT_ADDR_PAIR_SEQ_CONTROL:
            reg_rdata <= {4'h0, sequential_function_select_q};
          `CCLUT_ADDR_STATUS:
            reg_rdata <= {3'h0, pair_sequential_output, 2'h0,
                          table_output_event};
          `CCLUT_ADDR_T0_CONTROL_A: reg_rdata <= table_control_a_q[0];
          `CCLUT_ADDR_T0_CONTROL_B: reg_rdata <= table_control_b_q[0];
          `CCLUT_ADDR_T0_CONTROL_C: reg_rdata <= table_control_c_q[0];
          `CCLUT_ADDR_T0_TRUTH: reg_rdata <= table_truth_bits_q[0];
          `CCLUT_ADDR_T1_CONTROL_A: reg_rdata <= table_control_a_q[1];
          `CCLUT_ADDR_T1_CONTROL_B: reg_rdata <= table_control_b_q[1];
          `CCLUT_ADDR_T1_CONTROL_C: reg_rdata <= table_control_c_q[1];
          `CCLUT_ADDR_T1_TRUTH: reg_rdata <= table_truth_bits_q[1];
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Input selection and truth tables
  // ----------------------------------------------------------------
  reg seq_q;
  reg [1:0] lut_raw;
  reg [2:0] idx [0:1];

  function sel_src;
    input [3:0] sel;
    input pin;
    input tmr;
    input link;
    input fb;
    begin
      case (sel)
        `CCLUT_SRC_MASK: sel_src = 1'b0; // R02
        `CCLUT_SRC_FEEDBACK: sel_src = fb; // R11
        `CCLUT_SRC_LINK: sel_src = link; // R12
        `CCLUT_SRC_EVENT_LINE_ZERO: sel_src = event_line_zero; // R13
        `CCLUT_SRC_EVENT_LINE_ONE: sel_src = event_line_one; // R13
        `CCLUT_SRC_PIN: sel_src = pin; // R15
        `CCLUT_SRC_COMPARATOR: sel_src = comparator_out; // R15
        `CCLUT_SRC_TIMER_A: sel_src = tmr; // R15
        `CCLUT_SRC_TIMER_B: sel_src = ~tmr; // R15
        default: sel_src = 1'b0;
      endcase
    end
  endfunction

  // Link of the last table wraps to nothing and reads low.
  wire [1:0] link_src;
  assign link_src = {1'b0, lut_raw[1]}; // R12

  integer t, u, v, w;
  always @* begin
    for (t = 0; t < 2; t = t + 1) begin
      idx[t][0] = sel_src(table_control_b_q[t][3:0], table_input_pins[3*t],
                          timer_waveform[t], link_src[t], seq_q);
      idx[t][1] = sel_src(table_control_b_q[t][7:4], table_input_pins[3*t+1],
                          timer_waveform[t], link_src[t], seq_q);
      idx[t][2] = sel_src(table_control_c_q[t][3:0], table_input_pins[3*t+2],
                          timer_waveform[t], link_src[t], seq_q);
    end
  end

  always @* begin
    for (u = 0; u < 2; u = u + 1) begin
      if (!run[u]) begin
        lut_raw[u] = 1'b0; // R22
      end else if (table_control_a_q[u][`CCLUT_CA_CLKSEL]) begin
        lut_raw[u] = table_truth_bits_q[u][{1'b0, idx[u][1:0]}]; // R20
      end else begin
        lut_raw[u] = table_truth_bits_q[u][idx[u]]; // R01
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock qualification: rising edge of input 2 replaces the clock
  // ----------------------------------------------------------------
  reg [1:0] in2_s1_q;
  reg [1:0] in2_s2_q;
  reg [1:0] in2_s3_q;
  wire [1:0] tick;
  always @(posedge clk) begin
    if (sys_rst) begin
      in2_s1_q <= 2'b00;
      in2_s2_q <= 2'b00;
      in2_s3_q <= 2'b00;
    end else if (clk_en) begin
      in2_s1_q <= {idx[1][2], idx[0][2]};
      in2_s2_q <= in2_s1_q;
      in2_s3_q <= in2_s2_q;
    end
  end
  assign tick[0] = ~table_control_a_q[0][`CCLUT_CA_CLKSEL] |
                   (in2_s2_q[0] & ~in2_s3_q[0]); // R08
  assign tick[1] = ~table_control_a_q[1][`CCLUT_CA_CLKSEL] |
                   (in2_s2_q[1] & ~in2_s3_q[1]); // R08

  // ----------------------------------------------------------------
  // Output stage: synchroniser, filter and edge detector
  // ----------------------------------------------------------------
  reg [1:0] st1_q;
  reg [1:0] st2_q;
  reg [1:0] st3_q;
  reg [1:0] edge_q;
  reg [1:0] stage_out;
  // The filter passes a level only after three equal samples.
  reg [1:0] filt_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      st1_q <= 2'b00;
      st2_q <= 2'b00;
      st3_q <= 2'b00;
      edge_q <= 2'b00;
      filt_q <= 2'b00;
    end else if (clk_en) begin
      for (v = 0; v < 2; v = v + 1) begin
        if (!run[v]) begin
          st1_q[v] <= 1'b0; // R21 R22
          st2_q[v] <= 1'b0;
          st3_q[v] <= 1'b0;
          edge_q[v] <= 1'b0;
          filt_q[v] <= 1'b0; // R21
        end else if (tick[v]) begin
          st1_q[v] <= lut_raw[v];
          st2_q[v] <= st1_q[v];
          st3_q[v] <= st2_q[v];
          edge_q[v] <= stage_out[v];
          if (st1_q[v] == st2_q[v] && st2_q[v] == st3_q[v]) begin
            filt_q[v] <= st3_q[v]; // R21
          end
        end
      end
    end
  end

  reg [1:0] final_out;
  always @* begin
    for (w = 0; w < 2; w = w + 1) begin
      case (table_control_a_q[w][`CCLUT_CA_FILT_HI:`CCLUT_CA_FILT_LO])
        `CCLUT_FILT_OFF: stage_out[w] = lut_raw[w];
        `CCLUT_FILT_SYNC: stage_out[w] = st2_q[w]; // R17
        `CCLUT_FILT_FILTER: stage_out[w] = filt_q[w]; // R21
        default: stage_out[w] = 1'b0;
      endcase
      if (table_control_a_q[w][`CCLUT_CA_EDGE]) begin
        final_out[w] = stage_out[w] & ~edge_q[w]; // R17
      end else begin
        final_out[w] = stage_out[w];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequential element, timed by table 0's clock choice
  // ----------------------------------------------------------------
  reg seq_d;
  always @* begin
    seq_d = seq_q;
    case (sequential_function_select_q)
      `CCLUT_SEQ_DFF: if (final_out[1]) seq_d = final_out[0]; // R16
      `CCLUT_SEQ_JK: begin
        case ({final_out[0], final_out[1]})
          2'b01: seq_d = 1'b0;
          2'b10: seq_d = 1'b1;
          2'b11: seq_d = ~seq_q;
          default: seq_d = seq_q;
        endcase
      end
      `CCLUT_SEQ_DLATCH: if (final_out[1]) seq_d = final_out[0]; // R16
      `CCLUT_SEQ_RS: begin
        if (final_out[0]) seq_d = 1'b1;
        else if (final_out[1]) seq_d = 1'b0;
      end
      default: seq_d = 1'b0;
    endcase
  end

  // The latch forms update every cycle so they follow the gate level.
  wire seq_latch;
  assign seq_latch =
    (sequential_function_select_q == `CCLUT_SEQ_DLATCH) ||
    (sequential_function_select_q == `CCLUT_SEQ_RS);

  always @(posedge clk) begin
    if (sys_rst) begin
      seq_q <= 1'b0;
    end else if (clk_en) begin
      if (!run[0]) begin
        seq_q <= 1'b0; // R22
      end else if (tick[0] || seq_latch) begin
        seq_q <= seq_d; // R09 R16
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs; the halt input is not used so debug never stops the block
  // ----------------------------------------------------------------
  wire seq_on;
  assign seq_on = sequential_function_select_q != `CCLUT_SEQ_OFF;
  always @(posedge clk) begin
    if (sys_rst) begin
      table_output_pin <= 2'b00;
      table_output_pin_oe <= 2'b00;
      table_output_event <= 2'b00;
      pair_sequential_output <= 1'b0;
    end else if (clk_en) begin // R18 R19
      table_output_event[0] <= seq_on ? seq_q : final_out[0]; // R17 R18
      table_output_event[1] <= final_out[1]; // R17
      table_output_pin[0] <= seq_on ? seq_q : final_out[0]; // R17
      table_output_pin[1] <= final_out[1];
      table_output_pin_oe[0] <= table_control_a_q[0][`CCLUT_CA_OUTEN];
      table_output_pin_oe[1] <= table_control_a_q[1][`CCLUT_CA_OUTEN];
      pair_sequential_output <= seq_q;
    end
  end

endmodule // cclut_logic

// [cclut_checker_asserts.sv]
// Assertion checker bound to the ports of the logic block.
`timescale 1ns/1ns
module cclut_checker #(
  parameter NUM_TABLES = 2
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  input wire [7:0] reg_rdata,
  // Results
  input wire [NUM_TABLES-1:0] table_output_pin,
  input wire [NUM_TABLES-1:0] table_output_event,
  input wire pair_sequential_output
);
  // ------------------------------------------------------------
  // Shadow copies of the enables, sequential select and table 0 controls A and B
  // ------------------------------------------------------------
  reg glob_q;
  reg en0_q;
  reg en1_q;
  reg [3:0] seq_q;
  reg [7:0] ca0_q;
  reg [7:0] cb0_q;
  wire wr_go;
  wire rd_go;
  assign wr_go = reg_we && clk_en;
  assign rd_go = reg_re && clk_en;
  always @(posedge clk) begin
    if (sys_rst) begin
      glob_q <= 1'b0;
      en0_q <= 1'b0;
      en1_q <= 1'b0;
      seq_q <= 4'h0;
      ca0_q <= 8'h00;
      cb0_q <= 8'h00;
    end else if (wr_go) begin
      if (reg_addr == 4'h0) glob_q <= reg_wdata[0];
      if (reg_addr == 4'h1 && !en0_q) seq_q <= reg_wdata[3:0];
      if (reg_addr == 4'h5) en0_q <= reg_wdata[0];
      if (reg_addr == 4'h5 && (reg_wdata[0] || !en0_q)) ca0_q <= reg_wdata;
      if (reg_addr == 4'h5 && !reg_wdata[0] && en0_q)
        ca0_q <= {ca0_q[7:1], 1'b0};
      if (reg_addr == 4'h6 && !en0_q) cb0_q <= reg_wdata;
      if (reg_addr == 4'h9) en1_q <= reg_wdata[0];
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    $past(sys_rst) |-> table_output_event == '0 && !pair_sequential_output)
    else $error("outputs not low after reset");
  a_global_off: assert property (!glob_q [*3] |->
    table_output_event == '0 && table_output_pin == '0)
    else $error("outputs active while block disabled");
  a_table0_off: assert property (!en0_q [*3] |->
    !table_output_event[0] && !table_output_pin[0])
    else $error("table 0 output active while disabled");
  a_table1_off: assert property (
    !$past(en1_q, 2) && !$past(en1_q) && !en1_q |-> !table_output_event[1])
    else $error("table 1 output active while disabled");
  a_seq_cleared: assert property ($fell(en0_q) |->
    ##2 !pair_sequential_output [*2])
    else $error("sequential output not cleared on disable");
  a_seq_guard: assert property (
    $past(rd_go) && $past(reg_addr) == 4'h1 |-> reg_rdata[3:0] == seq_q)
    else $error("sequential select changed while protected");
  a_ctla_guard: assert property (
    $past(rd_go) && $past(reg_addr) == 4'h5 |-> reg_rdata == ca0_q)
    else $error("control A protection broken");
  a_ctlb_guard: assert property (
    $past(rd_go) && $past(reg_addr) == 4'h6 |-> reg_rdata == cb0_q)
    else $error("control B protection broken");
endmodule // cclut_checker

bind cclut_logic cclut_checker #(.NUM_TABLES(NUM_TABLES)) u_checker (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .table_output_pin(table_output_pin),
  .table_output_event(table_output_event),
  .pair_sequential_output(pair_sequential_output));

// [cclut_far_end.sv]
// Model of the pins, event lines and peripherals feeding the block.
`timescale 1ns/1ns
module cclut_far_end (
  // Clock and requested levels
  input wire clk,
  input wire [10:0] level_req,
  input wire events_routed,
  // Lines into the block
  output reg [5:0] table_input_pins = 6'h00,
  output reg event_line_zero = 1'b0,
  output reg event_line_one = 1'b0,
  output reg comparator_out = 1'b0,
  output reg [1:0] timer_waveform = 2'h0
);
  // Event lines stay low until the event routing has been set up.
  always @(posedge clk) begin
    table_input_pins <= level_req[5:0];
    event_line_zero <= events_routed & level_req[6];
    event_line_one <= events_routed & level_req[7];
    comparator_out <= level_req[8];
    timer_waveform <= level_req[10:9];
  end
endmodule // cclut_far_end

// [cclut_logic_bench.sv]
// Self-checking bench for the look-up table pair.
`timescale 1ns/1ns
module cclut_logic_bench;
  // ------------------------------------------------------------
  // Stimulus, wiring and counters
  // ------------------------------------------------------------
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_we = 1'b0;
  reg reg_re = 1'b0;
  reg debug_halt = 1'b0;
  reg [10:0] lv = 11'h000;
  reg routed = 1'b0;
  reg [31:0] rng = 32'h00005786;
  reg [7:0] tt;
  reg [3:0] s0;
  reg [3:0] s1;
  reg [3:0] s2;
  reg [3:0] base;
  reg n;
  reg exp_q;
  integer i;
  integer mismatches = 0;
  integer check_count = 0;
  wire [7:0] reg_rdata;
  wire [5:0] pins;
  wire ev0;
  wire ev1;
  wire cmp;
  wire [1:0] tmr;
  wire [1:0] out_pin;
  wire [1:0] out_oe;
  wire [1:0] out_ev;
  wire seq_out;
  always #5 clk = ~clk;
  cclut_logic #(.NUM_TABLES(2)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .table_input_pins(pins),
    .event_line_zero(ev0), .event_line_one(ev1), .comparator_out(cmp),
    .timer_waveform(tmr), .debug_halt(debug_halt),
    .table_output_pin(out_pin), .table_output_pin_oe(out_oe),
    .table_output_event(out_ev), .pair_sequential_output(seq_out));
  cclut_far_end u_far (
    .clk(clk), .level_req(lv), .events_routed(routed),
    .table_input_pins(pins), .event_line_zero(ev0), .event_line_one(ev1),
    .comparator_out(cmp), .timer_waveform(tmr));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [3:0] code(input [2:0] r);
    code = (r == 3'h0 || r == 3'h7) ? 4'h0 : {1'b0, r} + 4'h2;
  endfunction
  // Level seen on one table input for a given source code.
  function src(input [3:0] s, input [10:0] l, input t, input [1:0] k);
    case (s)
      4'h3: src = l[6];
      4'h4: src = l[7];
      4'h5: src = l[3 * t + k];
      4'h6: src = l[8];
      4'h7: src = l[9 + t];
      4'h8: src = ~l[9 + t];
      default: src = 1'b0;
    endcase
  endfunction
  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
      @(posedge clk);
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task ochk(input got, input exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task rchk(input [3:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      @(posedge clk);
    end
  endtask
  task cfg(input [3:0] a, input [7:0] b, input [7:0] c, input [7:0] t,
           input [7:0] e);
    begin
      wr(a, 8'h00);
      wr(a + 4'h1, b);
      wr(a + 4'h2, c);
      wr(a + 4'h3, t);
      wr(a, e);
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    final_report;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 13; i = i + 1) rchk(i[3:0], 8'h00);
    routed <= 1'b1;
    wr(4'h0, 8'h01);
    for (i = 0; i < 24; i = i + 1) begin
      n = i[0];
      base = n ? 4'h9 : 4'h5;
      rng = xs(rng);
      s0 = code(rng[2:0]);
      s1 = code(rng[5:3]);
      s2 = code(rng[8:6]);
      tt = rng[23:16];
      cfg(base, {s1, s0}, {4'h0, s2}, tt, 8'h09);
      rng = xs(rng);
      lv <= rng[10:0];
      debug_halt <= rng[12];
      settle;
      exp_q = tt[{src(s2, lv, n, 2'h2), src(s1, lv, n, 2'h1),
                  src(s0, lv, n, 2'h0)}];
      ochk(out_ev[n], exp_q);
      ochk(out_pin[n], exp_q);
      ochk(out_oe[n], 1'b1);
      @(posedge clk);
    end
    rng = xs(rng);
    tt = rng[7:0];
    cfg(4'h9, 8'h55, 8'h05, tt, 8'h09);
    cfg(4'h5, 8'h02, 8'h00, 8'hAA, 8'h09);
    lv <= rng[18:8];
    settle;
    ochk(out_ev[0], tt[lv[5:3]]);
    @(posedge clk);
    wr(4'h0, 8'h00);
    cfg(4'h5, 8'h55, 8'h05, 8'h0F, 8'h49);
    wr(4'h0, 8'h01);
    lv <= rng[28:18] | 11'h004;
    settle;
    ochk(out_ev[0], 1'b1);
    @(posedge clk);
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h00);
    rchk(4'h5, 8'h48);
    wr(4'h5, 8'h09);
    rchk(4'h5, 8'h09);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h33);
    rchk(4'h6, 8'h55);
    wr(4'h8, 8'h12);
    rchk(4'h8, 8'h0F);
    wr(4'h1, 8'h01);
    rchk(4'h1, 8'h00);
    wr(4'h5, 8'h19);
    rchk(4'h5, 8'h19);
    wr(4'h3, 8'hFF);
    rchk(4'h3, 8'h00);
    lv <= 11'h000;
    settle;
    ochk(out_ev[0], 1'b1);
    @(posedge clk);
    wr(4'h5, 8'h29);
    settle;
    @(posedge clk);
    lv <= 11'h004;
    @(posedge clk);
    lv <= 11'h000;
    repeat (6) begin
      @(posedge clk);
      #1;
      ochk(out_ev[0], 1'b1);
    end
    @(posedge clk);
    wr(4'h5, 8'h08);
    settle;
    ochk(out_ev[0], 1'b0);
    @(posedge clk);
    wr(4'h5, 8'hA9);
    settle;
    ochk(out_ev[0], 1'b1);
    @(posedge clk);
    #1;
    ochk(out_ev[0], 1'b0);
    ochk(out_ev[1], tt[0]);
    @(posedge clk);
    wr(4'h0, 8'h00);
    settle;
    ochk(out_ev[1], 1'b0);
    ochk(out_pin[1], 1'b0);
    @(posedge clk);
    wr(4'h0, 8'h01);
    for (i = 1; i < 5; i = i + 1) begin
      wr(4'h5, 8'h00);
      wr(4'h1, i[7:0]);
      tt = (i == 1 || i == 3) ? 8'h55 : 8'h00;
      cfg(4'h9, 8'h01, 8'h00, tt, 8'h09);
      cfg(4'h5, 8'h00, 8'h00, 8'hFF, 8'h09);
      repeat (8) @(posedge clk);
      #1;
      ochk(seq_out, 1'b1);
      ochk(out_ev[0], 1'b1);
      ochk(out_ev[1], 1'b0);
      @(posedge clk);
    end
    final_report;
  end
endmodule // cclut_logic_bench
